// [inc/vcu_cfg.svh]
`ifndef VCU_CFG_SVH
`define VCU_CFG_SVH
// core clock figures in kHz, large and small device variants
`define VCU_FAST_KHZ_BIG    400000
`define VCU_SLOW_KHZ_BIG    100000
`define VCU_FAST_KHZ_SMALL  266660
`define VCU_SLOW_KHZ_SMALL  66660
`define VCU_REF_KHZ         100000
// widths and reset values
`define VCU_PIX_W           8
`define VCU_FIFO_DEPTH      8
`define VCU_TTP_W           4
`define VCU_TTP_RST         4'h0
`define VCU_STOPPED_RST     1'b1
`endif

// [inc/vcu_pkg.sv]
package vcu_pkg;
	typedef enum logic [1:0]
	{
		VCU_IDLE  = 2'b00,
		VCU_ARMED = 2'b01,
		VCU_GRAB  = 2'b10,
		VCU_DRAIN = 2'b11
	} vcu_state_t;

	typedef enum logic
	{
		VCU_SRC_SERIAL   = 1'b0,
		VCU_SRC_PARALLEL = 1'b1
	} vcu_src_t;
endpackage : vcu_pkg

// [inc/vcu_pix_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface vcu_pix_if #(parameter int W = 8);
	logic [W-1:0] data;
	logic         valid;
	logic         ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : vcu_pix_if
`default_nettype wire

// [design/vcu_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module vcu_fifo
	import vcu_pkg::*;
#(
	parameter int W     = 8,
	parameter int DEPTH = 8
)(
	input  wire logic clk,
	input  wire logic rst_n,
	vcu_pix_if.snk    wr,
	vcu_pix_if.src    rd
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	logic          push;
	logic          pop;

	// -----------------------------------------------------------
	// handshakes
	// -----------------------------------------------------------
	// the count is one bit wider than the pointers, so full is exact
	assign wr.ready = (cnt_r != (AW+1)'(DEPTH));
	assign rd.valid = (cnt_r != '0);
	assign rd.data  = mem_r[rp_r];
	assign push     = wr.valid && wr.ready;
	assign pop      = rd.valid && rd.ready;

	// storage, written by index
	always_ff @(posedge clk)
	begin
		if (push)
			mem_r[wp_r] <= wr.data;
	end

	// pointers wrap at depth, so depth need not be a power of two
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end
		else
		begin
			if (push)
				wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
			if (pop)
				rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_no_overfill;
		cnt_r == (AW+1)'(DEPTH) |-> !wr.ready ##1 cnt_r <= (AW+1)'(DEPTH);
	endproperty
	a_no_overfill: assert property (p_no_overfill)
		else $error("fifo filled beyond depth");
endmodule : vcu_fifo
`default_nettype wire

// [design/vcu_ctrl.sv]
// Summary of operation
// - shadow mode set before parallel select leaves serial source in use until a serial frame start.
// - unit stays module-stopped after power-up until reset release.
// - large variants derive slow core rate of 100 MHz from 400 MHz.
// - small variant uses 266.66 MHz fast and 66.66 MHz slow clocks.
`timescale 1ns/1ps
`default_nettype none
`include "vcu_cfg.svh"
module vcu_ctrl
	import vcu_pkg::*;
#(
	parameter bit SMALL_VARIANT = 1'b0,
	parameter int PIX_W         = `VCU_PIX_W,
	parameter int FIFO_DEPTH    = `VCU_FIFO_DEPTH
)(
	input  wire logic                  REF_CLK,
	input  wire logic                  RSTN,
	input  wire logic                  SOFT_RESET_ASSERT_BIT,
	input  wire logic                  SOFT_RESET_RELEASE_BIT,
	input  wire logic                  MODULE_ENABLE,
	input  wire logic                  CONTINUOUS_GRAB,
	input  wire logic                  SINGLE_GRAB,
	input  wire logic                  SHADOW_UPDATE_MODE,
	input  wire logic                  PARALLEL_PIN_INPUT_SELECT,
	input  wire logic                  VSYNC_FIELD_TOGGLE_ENABLE,
	input  wire logic [`VCU_TTP_W-1:0] TOGGLE_TRANSITION_PERIOD,
	input  wire logic                  FLAG_CLEAR,
	input  wire logic                  PIX_CLK,
	input  wire logic                  PIX_VSYNC,
	input  wire logic [PIX_W-1:0]      PIX_DATA,
	input  wire logic                  SER_FRAME_START,
	input  wire logic                  SER_FRAME_END,
	input  wire logic                  SER_VALID,
	input  wire logic [PIX_W-1:0]      SER_DATA,
	output var  logic                  MODULE_STOPPED,
	output var  logic                  FRAME_GRAB_RUNNING,
	output var  logic                  FRAME_END_FLAG,
	output var  logic                  FIELD_FLAG,
	output var  logic                  PARALLEL_ACTIVE,
	output var  logic                  SLOW_CORE_EN,
	output logic [PIX_W-1:0]           OUT_DATA,
	output logic                       OUT_VALID,
	input  wire logic                  OUT_READY,
	output logic                       IN_OVERRUN
);
	// -----------------------------------------------------------
	// core clock divider
	// -----------------------------------------------------------
	localparam int FAST_KHZ = SMALL_VARIANT ? `VCU_FAST_KHZ_SMALL
	                                        : `VCU_FAST_KHZ_BIG;
	localparam int SLOW_KHZ = SMALL_VARIANT ? `VCU_SLOW_KHZ_SMALL
	                                        : `VCU_SLOW_KHZ_BIG;
	localparam int DIV      = (FAST_KHZ / SLOW_KHZ < 1) ? 1
	                                                    : FAST_KHZ / SLOW_KHZ;
	logic [3:0] div_r;

	// fast rate is the reference itself; slow is a 1-in-DIV enable
	always_ff @(posedge REF_CLK)
	begin
		if (!RSTN)
			div_r <= '0;
		else
			div_r <= (div_r == 4'(DIV-1)) ? '0 : div_r + 4'h1;
	end
	assign SLOW_CORE_EN = (div_r == 4'(DIV-1));

	// -----------------------------------------------------------
	// module stop and soft reset
	// -----------------------------------------------------------
	logic stopped_r;
	logic in_srst_r;
	logic hold;

	// only a release ends the stopped state, so power-up alone never runs
	always_ff @(posedge REF_CLK)
	begin
		if (!RSTN)
		begin
			stopped_r <= `VCU_STOPPED_RST;
			in_srst_r <= 1'b0;
		end
		else if (SOFT_RESET_ASSERT_BIT)
			in_srst_r <= 1'b1;
		else if (SOFT_RESET_RELEASE_BIT)
		begin
			in_srst_r <= 1'b0;
			stopped_r <= 1'b0;
		end
	end
	assign hold           = stopped_r || in_srst_r || SOFT_RESET_ASSERT_BIT;
	assign MODULE_STOPPED = stopped_r;

	// -----------------------------------------------------------
	// parallel pin sampling, two flops before any logic
	// -----------------------------------------------------------
	logic [PIX_W+1:0] pin_s1_r;
	logic [PIX_W+1:0] pin_s2_r;
	logic             pclk_d_r;
	logic             vs_d_r;

	always_ff @(posedge REF_CLK)
	begin
		pin_s1_r <= {PIX_CLK, PIX_VSYNC, PIX_DATA};
		pin_s2_r <= pin_s1_r;
	end

	// edge memory reads only the second stage
	always_ff @(posedge REF_CLK)
	begin
		if (!RSTN)
		begin
			pclk_d_r <= 1'b0;
			vs_d_r   <= 1'b1;
		end
		else if (pin_s2_r[PIX_W+1] && !pclk_d_r)
			vs_d_r <= pin_s2_r[PIX_W];
		if (RSTN)
			pclk_d_r <= pin_s2_r[PIX_W+1];
	end

	logic par_edge;
	logic par_fs;
	logic par_fe;
	assign par_edge = pin_s2_r[PIX_W+1] && !pclk_d_r;
	// vsync high is blanking: falling starts a frame, rising ends it
	assign par_fs   = par_edge && vs_d_r && !pin_s2_r[PIX_W];
	assign par_fe   = par_edge && !vs_d_r && pin_s2_r[PIX_W];

	// -----------------------------------------------------------
	// source selection with shadow update
	// -----------------------------------------------------------
	logic src_r;
	logic fs;
	logic fe;
	assign fs = src_r ? par_fs : SER_FRAME_START;
	assign fe = src_r ? par_fe : SER_FRAME_END;

	// shadowed select only lands on a frame start of the current source;
	// a grounded serial link never gives one, so the switch is stuck
	always_ff @(posedge REF_CLK)
	begin
		if (!RSTN || hold)
			src_r <= VCU_SRC_SERIAL;
		else if (!SHADOW_UPDATE_MODE || fs)
			src_r <= PARALLEL_PIN_INPUT_SELECT;
	end
	assign PARALLEL_ACTIVE = src_r;

	// -----------------------------------------------------------
	// capture state machine
	// -----------------------------------------------------------
	vcu_state_t st_r;
	logic       grab_req;
	logic       single_r;
	assign grab_req = MODULE_ENABLE && (CONTINUOUS_GRAB || SINGLE_GRAB);

	// running follows the frame, not the request, so a stop lands at fe
	always_ff @(posedge REF_CLK)
	begin
		if (!RSTN || hold)
		begin
			st_r     <= VCU_IDLE;
			single_r <= 1'b0;
		end
		else
		begin
			case (st_r)
			VCU_IDLE:
				if (grab_req)
					st_r <= VCU_ARMED;
			VCU_ARMED:
				if (!grab_req)
					st_r <= VCU_IDLE;
				else if (fs)
				begin
					st_r     <= VCU_GRAB;
					single_r <= !CONTINUOUS_GRAB;
				end
			VCU_GRAB:
				if (fe && (!grab_req || single_r))
					st_r <= VCU_DRAIN;
			VCU_DRAIN:
				if (!grab_req)
					st_r <= VCU_IDLE;
			default:
				st_r <= VCU_IDLE;
			endcase
		end
	end
	assign FRAME_GRAB_RUNNING = (st_r == VCU_GRAB);

	// -----------------------------------------------------------
	// frame end and field flags, set beats clear
	// -----------------------------------------------------------
	logic [`VCU_TTP_W-1:0] ttp_cnt_r;
	logic                  fe_flag_r;
	logic                  fld_flag_r;
	logic                  toggle;
	assign toggle = VSYNC_FIELD_TOGGLE_ENABLE && fs &&
	                (ttp_cnt_r == TOGGLE_TRANSITION_PERIOD);

	// field toggles after the programmed number of extra frame starts
	always_ff @(posedge REF_CLK)
	begin
		if (!RSTN || hold || !VSYNC_FIELD_TOGGLE_ENABLE)
			ttp_cnt_r <= `VCU_TTP_RST;
		else if (fs)
			ttp_cnt_r <= toggle ? `VCU_TTP_RST : ttp_cnt_r + 4'h1;
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RSTN || hold)
		begin
			fe_flag_r  <= 1'b0;
			fld_flag_r <= 1'b0;
		end
		else
		begin
			fe_flag_r  <= (st_r == VCU_GRAB && fe) ||
			              (fe_flag_r && !FLAG_CLEAR);
			fld_flag_r <= (st_r != VCU_IDLE && toggle) ||
			              (fld_flag_r && !FLAG_CLEAR);
		end
	end
	assign FRAME_END_FLAG = fe_flag_r;
	assign FIELD_FLAG     = fld_flag_r;

	// -----------------------------------------------------------
	// pixel path into the buffer
	// -----------------------------------------------------------
	vcu_pix_if #(.W(PIX_W)) in_if ();
	vcu_pix_if #(.W(PIX_W)) out_if ();
	logic [PIX_W-1:0] pix_r;
	logic             pix_v_r;
	logic             ovr_r;

	// a full buffer cannot stall a sensor, so lost pixels are flagged
	always_ff @(posedge REF_CLK)
	begin
		if (!RSTN || hold)
		begin
			pix_r   <= '0;
			pix_v_r <= 1'b0;
			ovr_r   <= 1'b0;
		end
		else
		begin
			pix_v_r <= (st_r == VCU_GRAB) &&
			           (src_r ? (par_edge && !pin_s2_r[PIX_W]) : SER_VALID);
			pix_r   <= src_r ? pin_s2_r[PIX_W-1:0] : SER_DATA;
			ovr_r   <= ovr_r || (pix_v_r && !in_if.ready);
		end
	end
	assign in_if.valid   = pix_v_r;
	assign in_if.data    = pix_r;
	assign out_if.ready  = OUT_READY;
	assign OUT_VALID     = out_if.valid;
	assign OUT_DATA      = out_if.data;
	assign IN_OVERRUN    = ovr_r;

	vcu_fifo #(.W(PIX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk   (REF_CLK),
		.rst_n (RSTN && !hold),
		.wr    (in_if),
		.rd    (out_if)
	);

	// -----------------------------------------------------------
	// checks
	// -----------------------------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);

	sequence s_armed_start;
		st_r == VCU_ARMED && grab_req && fs && !hold;
	endsequence
	sequence s_stop_end;
		st_r == VCU_GRAB && fe && !grab_req && !hold;
	endsequence

	property p_stopped_idle;
		stopped_r |-> !FRAME_GRAB_RUNNING && !FRAME_END_FLAG;
	endproperty
	a_stopped_idle: assert property (p_stopped_idle)
		else $error("running while module stopped");

	property p_release;
		stopped_r && SOFT_RESET_RELEASE_BIT && !SOFT_RESET_ASSERT_BIT
		|=> !MODULE_STOPPED;
	endproperty
	a_release: assert property (p_release)
		else $error("release did not leave stopped state");

	property p_run_rise;
		s_armed_start |=> FRAME_GRAB_RUNNING;
	endproperty
	a_run_rise: assert property (p_run_rise)
		else $error("running not set at frame start");

	property p_run_fall;
		s_stop_end |=> !FRAME_GRAB_RUNNING ##1 !FRAME_GRAB_RUNNING;
	endproperty
	a_run_fall: assert property (p_run_fall)
		else $error("running not cleared at frame end");

	property p_run_keeps;
		FRAME_GRAB_RUNNING && !fe && !hold |=> FRAME_GRAB_RUNNING;
	endproperty
	a_run_keeps: assert property (p_run_keeps)
		else $error("running dropped mid frame");

	property p_shadow_stuck;
		SHADOW_UPDATE_MODE && !fs && !hold && !src_r |=> !PARALLEL_ACTIVE;
	endproperty
	a_shadow_stuck: assert property (p_shadow_stuck)
		else $error("shadowed select applied without frame start");

	property p_flag_set_wins;
		st_r == VCU_GRAB && fe && !hold |=> FRAME_END_FLAG;
	endproperty
	a_flag_set_wins: assert property (p_flag_set_wins)
		else $error("frame end lost");

	property p_slow_rate;
		SLOW_CORE_EN |=> !SLOW_CORE_EN [*3] ##1 SLOW_CORE_EN;
	endproperty
	a_slow_rate: assert property (p_slow_rate)
		else $error("slow enable not one in four");
endmodule : vcu_ctrl
`default_nettype wire

// [testbench/vcu_cam_model.sv]
`timescale 1ns/1ps
`default_nettype none
// sensor model: serial markers on the ref clock, pins on their own clock
module vcu_cam_model (
	input  wire logic  clk,
	output logic       pix_clk,
	output logic       pix_vsync,
	output logic [7:0] pix_data,
	output logic       ser_fs,
	output logic       ser_fe,
	output logic       ser_valid,
	output logic [7:0] ser_data
);
	// pin clock stands still between frames, vsync idles in blanking
	initial
	begin
		{pix_clk, ser_fs, ser_fe, ser_valid} = 4'h0;
		pix_vsync = 1'b1;
		pix_data = 8'h5a;
		ser_data = 8'ha5;
	end
	// one-cycle frame start or frame end marker
	task ser_mark(input bit fe);
		@(posedge clk);
		ser_fs <= !fe;
		ser_fe <= fe;
		@(posedge clk);
		{ser_fs, ser_fe} <= 2'b00;
	endtask : ser_mark
	// bytes on the link; idle data is inverted so stale bytes never match
	task ser_pixels(input int n, input int keep);
		logic [7:0] d;
		for (int i = 0; i < n; i++)
		begin
			d = 8'($urandom);
			@(posedge clk);
			ser_valid <= 1'b1;
			ser_data <= d;
			if (i < keep)
				vcu_ctrl_tb.exp_q.push_back(d);
			@(posedge clk);
			ser_valid <= 1'b0;
			ser_data <= ~d;
		end
	endtask : ser_pixels
	// one 80 ns pin clock period
	task pcyc();
		#40 pix_clk = 1'b1;
		#40 pix_clk = 1'b0;
	endtask : pcyc
	// whole pin frame: blanking, active lines, blanking
	task par_frame(input int n, input int keep);
		logic [7:0] d;
		repeat (2)
		begin
			pix_data = ~pix_data;
			pcyc();
		end
		pix_vsync = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			d = 8'($urandom);
			pix_data = d;
			if (i < keep)
				vcu_ctrl_tb.exp_q.push_back(d);
			pcyc();
		end
		pix_vsync = 1'b1;
		repeat (2)
		begin
			pix_data = ~pix_data;
			pcyc();
		end
	endtask : par_frame
endmodule : vcu_cam_model
`default_nettype wire

// [testbench/vcu_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module vcu_ctrl_tb;
	logic       ref_clk, rstn, sra, srr, me, cc, sc, shadow_update_mode, psel, vsync_field_toggle_enable;
	logic       fclr, rdy, rdy_rand, chk_en;
	logic [3:0] ttp;
	wire        pclk, pvs, sfs, sfe, sv, stopped, running, fef, ffl, pact;
	wire        slow, ovalid, ovr;
	wire  [7:0] pd, sd, odata;
	wire  [6:0] obs;
	logic [7:0] exp_q[$];
	int         failures, checks, k;

	assign obs = {ovr, ovalid, pact, ffl, fef, stopped, running};

	vcu_ctrl vcu_ctrl_i (.REF_CLK(ref_clk), .RSTN(rstn),
		.SOFT_RESET_ASSERT_BIT(sra), .SOFT_RESET_RELEASE_BIT(srr),
		.MODULE_ENABLE(me), .CONTINUOUS_GRAB(cc), .SINGLE_GRAB(sc),
		.SHADOW_UPDATE_MODE(shadow_update_mode), .PARALLEL_PIN_INPUT_SELECT(psel),
		.VSYNC_FIELD_TOGGLE_ENABLE(vsync_field_toggle_enable), .TOGGLE_TRANSITION_PERIOD(ttp),
		.FLAG_CLEAR(fclr), .PIX_CLK(pclk), .PIX_VSYNC(pvs), .PIX_DATA(pd),
		.SER_FRAME_START(sfs), .SER_FRAME_END(sfe), .SER_VALID(sv),
		.SER_DATA(sd), .MODULE_STOPPED(stopped), .FRAME_GRAB_RUNNING(running),
		.FRAME_END_FLAG(fef), .FIELD_FLAG(ffl), .PARALLEL_ACTIVE(pact),
		.SLOW_CORE_EN(slow), .OUT_DATA(odata), .OUT_VALID(ovalid),
		.OUT_READY(rdy), .IN_OVERRUN(ovr));

	vcu_cam_model vcu_cam_model_i (.clk(ref_clk), .pix_clk(pclk),
		.pix_vsync(pvs), .pix_data(pd), .ser_fs(sfs), .ser_fe(sfe),
		.ser_valid(sv), .ser_data(sd));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task give_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task chkb(input string nm, input int sel, input logic v);
		chk(nm, {7'h00, v}, {7'h00, obs[sel]});
	endtask : chkb
	// bounded wait on one status output; running out ends the run
	task wait_for(input int sel, input logic v, input int lim);
		for (int i = 0; i < lim; i++)
		begin
			@(posedge ref_clk);
			#1;
			if (obs[sel] === v)
				return;
		end
		chkb("wait", sel, v);
		give_verdict();
	endtask : wait_for
	task pulse_clr();
		@(posedge ref_clk);
		fclr <= 1'b1;
		@(posedge ref_clk);
		fclr <= 1'b0;
	endtask : pulse_clr

	// clock, hang guard, stalling reader
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial
	begin
		#500000;
		failures++;
		give_verdict();
	end
	always @(posedge ref_clk)
		rdy <= rdy_rand ? 1'($urandom_range(1, 0)) : 1'b0;
	// oldest note against each byte taken; a byte with no note is a fault
	always @(posedge ref_clk)
	begin
		if (ovalid === 1'b1 && rdy === 1'b1 && chk_en)
		begin
			if (exp_q.size() == 0)
				chk("extra byte", 8'h00, 8'hff);
			else
				chk("out_data", exp_q.pop_front(), odata);
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(32'h38aa));
		{rstn, sra, srr, me, cc, sc, shadow_update_mode, psel, fclr, rdy_rand} = '0;
		vsync_field_toggle_enable = 1'b1;
		ttp = 4'h0;
		chk_en = 1'b1;
		repeat (20) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		#1 chkb("stopped", 1, 1'b1);
		// a grab asked for while stopped must be ignored
		me <= 1'b1;
		cc <= 1'b1;
		vcu_cam_model_i.ser_mark(1'b0);
		#1 chkb("running", 0, 1'b0);
		srr <= 1'b1;
		@(posedge ref_clk);
		srr <= 1'b0;
		wait_for(1, 1'b0, 4);
		repeat (2) @(posedge ref_clk);
		vcu_cam_model_i.ser_mark(1'b0);
		#1 chkb("running", 0, 1'b1);
		wait_for(3, 1'b1, 4);
		rdy_rand <= 1'b1;
		vcu_cam_model_i.ser_pixels(4, 4);
		// stop in mid-frame: running holds until the frame ends
		me <= 1'b0;
		cc <= 1'b0;
		vcu_cam_model_i.ser_pixels(2, 2);
		chkb("running", 0, 1'b1);
		vcu_cam_model_i.ser_mark(1'b1);
		wait_for(0, 1'b0, 3);
		chkb("frame_end", 2, 1'b1);
		pulse_clr();
		wait_for(2, 1'b0, 3);
		wait_for(5, 1'b0, 200);
		chk("queue", 8'h00, 8'(exp_q.size()));
		// single grab: one frame, then running drops with the request held
		sc <= 1'b1;
		me <= 1'b1;
		repeat (2) @(posedge ref_clk);
		vcu_cam_model_i.ser_mark(1'b0);
		vcu_cam_model_i.ser_pixels(1, 1);
		vcu_cam_model_i.ser_mark(1'b1);
		wait_for(0, 1'b0, 3);
		sc <= 1'b0;
		wait_for(5, 1'b0, 20);
		// reader stalled: ten bytes, eight fit, then drain
		rdy_rand <= 1'b0;
		me <= 1'b1;
		cc <= 1'b1;
		repeat (2) @(posedge ref_clk);
		vcu_cam_model_i.ser_mark(1'b0);
		vcu_cam_model_i.ser_pixels(10, 8);
		wait_for(6, 1'b1, 4);
		rdy_rand <= 1'b1;
		wait_for(5, 1'b0, 200);
		chk("queue", 8'h00, 8'(exp_q.size()));
		me <= 1'b0;
		cc <= 1'b0;
		vcu_cam_model_i.ser_mark(1'b1);
		wait_for(0, 1'b0, 3);
		// shadow mode set first with the link grounded: no switch
		shadow_update_mode <= 1'b1;
		@(posedge ref_clk);
		psel <= 1'b1;
		repeat (20) @(posedge ref_clk);
		chkb("par_active", 4, 1'b0);
		// new source: reset, shadow off, then select the pins
		sra <= 1'b1;
		psel <= 1'b0;
		repeat (3) @(posedge ref_clk);
		sra <= 1'b0;
		srr <= 1'b1;
		@(posedge ref_clk);
		srr <= 1'b0;
		shadow_update_mode <= 1'b0;
		@(posedge ref_clk);
		psel <= 1'b1;
		wait_for(4, 1'b1, 10);
		chkb("stopped", 1, 1'b0);
		me <= 1'b1;
		cc <= 1'b1;
		chk_en <= 1'b0;
		vcu_cam_model_i.par_frame(2, 0);
		wait_for(0, 1'b1, 20);
		wait_for(5, 1'b0, 60);
		pulse_clr();
		chk_en <= 1'b1;
		vcu_cam_model_i.par_frame(5, 5);
		wait_for(2, 1'b1, 20);
		wait_for(5, 1'b0, 200);
		chk("queue", 8'h00, 8'(exp_q.size()));
		// slow core rate is a quarter of the fast one
		k = 0;
		repeat (40)
		begin
			@(posedge ref_clk);
			#1 k += int'(slow);
		end
		chk("slow_en", 8'h0a, 8'(k));
		give_verdict();
	end
endmodule : vcu_ctrl_tb
`default_nettype wire
